/* File: verilog/awl_talker.sv */
/*
 * Bus controller end: software writes a setting over AHB-Lite and this
 * end sends talk address, listen address, four digits and unlisten.
 * Assumes a single AHB-Lite master and a listener on the link.
 */
// The implementer's own choices: the register offsets and the AHB-Lite slave port.
module awl_talker (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_b,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Link towards the listener.
  awl_link_if.ctl link
);

  // ************************************************************
  // Declarations.
  // ************************************************************
  typedef enum logic [1:0] {
    AWL_IDLE = 2'h0,
    AWL_WRFD = 2'h1,
    AWL_WDAC = 2'h3,
    AWL_WREL = 2'h2
  } awl_tx_t;

  awl_tx_t st_q;
  logic [2:0] idx_q;
  logic [31:0] set_q;
  logic done_q;
  logic wr_q;
  logic [7:0] wa_q;
  logic rfd_s;
  logic dac_s;
  logic addr_ph;
  logic start;
  logic done_clr;
  logic done_set;
  logic [2:0] nidx;
  logic [7:0] nbyte;
  logic natn;
  logic [7:0] dio_q;
  logic atn_q;
  logic dav_q;

  // ************************************************************
  // Bus slave.
  // ************************************************************
  // Zero wait states, always OKAY; size is ignored, whole words only.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addr_ph = hsel && hready && htrans[1];

  // Write address is held for the data phase; read data is registered.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wr_q <= 1'b0;
      wa_q <= 8'h00;
      hrdata <= 32'h00000000;
    end else begin
      wr_q <= addr_ph && hwrite;
      wa_q <= haddr;
      if (addr_ph && !hwrite) begin
        case (haddr)
          awl_pkg::REG_SETTING: hrdata <= set_q;
          awl_pkg::REG_STATUS: hrdata <= {30'h0, done_q, st_q != AWL_IDLE};
          default: hrdata <= 32'h00000000;
        endcase
      end
    end
  end

  // A setting written while busy is dropped; status shows busy.
  assign start = wr_q && wa_q == awl_pkg::REG_SETTING && st_q == AWL_IDLE;
  assign done_clr = wr_q && wa_q == awl_pkg::REG_STATUS &&
                    hwdata[awl_pkg::STAT_DONE_BIT];
  assign done_set = st_q == AWL_WREL && !dac_s && idx_q == awl_pkg::SEQ_LAST;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      set_q <= 32'h00000000;
    end else if (start) begin
      set_q <= hwdata & awl_pkg::SET_MASK;
    end
  end

  // Completion is sticky; a new completion beats a clear.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      done_q <= 1'b0;
    end else if (done_set) begin
      done_q <= 1'b1;
    end else if (done_clr) begin
      done_q <= 1'b0;
    end
  end

  // ************************************************************
  // Byte sequence.
  // ************************************************************
  awl_sync #(
    .W(2)
  ) u_sync (
    .mclk(mclk),
    .rst_b(rst_b),
    .d({link.rfd, link.dac}),
    .q({rfd_s, dac_s})
  );

  // Addresses go out first and exactly four digits follow.
  assign nidx = start ? 3'h0 : idx_q + 3'h1;
  always_comb begin
    natn = 1'b0;
    case (nidx)
      3'h0: begin
        nbyte = {awl_pkg::TALK_GROUP, awl_pkg::CTL_TALK_ADDR};
        natn = 1'b1;
      end
      3'h1: begin
        nbyte = {awl_pkg::LISTEN_GROUP,
                 set_q[awl_pkg::SET_ADDR_LSB +: 5]};
        natn = 1'b1;
      end
      3'h2: nbyte = set_q[awl_pkg::SET_HIGH_BIT] ?
                    awl_pkg::CHAR_HIGH : awl_pkg::CHAR_LOW;
      3'h3: nbyte = {awl_pkg::DIGIT_ZONE, set_q[8 +: 4]};
      3'h4: nbyte = {awl_pkg::DIGIT_ZONE, set_q[4 +: 4]};
      3'h5: nbyte = {awl_pkg::DIGIT_ZONE, set_q[0 +: 4]};
      default: begin
        nbyte = awl_pkg::UNLISTEN;
        natn = 1'b1;
      end
    endcase
  end

  // Byte is placed one state before its strobe rises.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= AWL_IDLE;
      idx_q <= 3'h0;
      dio_q <= 8'h00;
      atn_q <= 1'b0;
      dav_q <= 1'b0;
    end else begin
      case (st_q)
        AWL_IDLE: begin
          if (start) begin
            idx_q <= nidx;
            dio_q <= nbyte;
            atn_q <= natn;
            st_q <= AWL_WRFD;
          end
        end
        AWL_WRFD: begin
          if (rfd_s) begin
            dav_q <= 1'b1;
            st_q <= AWL_WDAC;
          end
        end
        AWL_WDAC: begin
          if (dac_s) begin
            dav_q <= 1'b0;
            st_q <= AWL_WREL;
          end
        end
        AWL_WREL: begin
          if (!dac_s) begin
            if (idx_q == awl_pkg::SEQ_LAST) begin
              atn_q <= 1'b0;
              st_q <= AWL_IDLE;
            end else begin
              idx_q <= nidx;
              dio_q <= nbyte;
              atn_q <= natn;
              st_q <= AWL_WRFD;
            end
          end
        end
        default: st_q <= AWL_IDLE;
      endcase
    end
  end

  assign link.dio = dio_q;
  assign link.atn = atn_q;
  assign link.dav = dav_q;

endmodule // awl_talker

/* File: verilog/awl_pkg.sv */
/*
 * Shared constants for the ASCII word listener and its bus controller.
 * Assumes both ends and the link interface are compiled after this file.
 */
// How it works
// - Device only listens, never drives data.
// - Controller addresses talker and listener before data.
// - Unaddressed device ignores data, keeps setting.
// - Four digits in order: range, then magnitude.
// - Range digit 1 is low, 2 high.
// - Magnitude is three BCD digits 000-999.
// - Fourth digit applies setting, no trigger.
// - Controller sends exactly four digits per setting.
// - Every fourth character updates, strays count too.
// - Unipolar: code scales linearly from zero.
// - Bipolar: 000 most negative, 999 most positive.
// - Bipolar code 500 gives zero both ranges.
// - Unipolar low: one millivolt per step.
// - Unipolar high: ten millivolts per step.
// - Bipolar low: two millivolts, offset one volt.
// - Bipolar high: twenty millivolts, offset ten volts.
// - Mode switch picks unipolar or bipolar mapping.
// - Listen address from switches; equal addresses share.
// - Five-bit address, all ones never listens.
// - Selector routes to voltage or current; local blocks.
// - Two listeners on one bus need distinct addresses.
package awl_pkg;

  // ************************************************************
  // Bus command bytes and addressing.
  // ************************************************************
  localparam logic [2:0] LISTEN_GROUP = 3'h1;
  localparam logic [2:0] TALK_GROUP = 3'h2;
  localparam logic [7:0] UNLISTEN = 8'h3F;
  localparam logic [4:0] ADDR_NONE = 5'h1F;
  // Controller's own talk address; the value is arbitrary.
  localparam logic [4:0] CTL_TALK_ADDR = 5'h15;

  // ************************************************************
  // Data word layout.
  // ************************************************************
  localparam logic [7:0] CHAR_LOW = 8'h31;
  localparam logic [7:0] CHAR_HIGH = 8'h32;
  localparam logic [3:0] DIGIT_ZONE = 4'h3;
  localparam logic [1:0] DIGIT_FIRST = 2'h0;
  localparam logic [1:0] DIGIT_LAST = 2'h3;
  localparam int MV_W = 17;

  // ************************************************************
  // Scaling: step in millivolts and bipolar offset.
  // ************************************************************
  localparam logic [4:0] STEP_UNI_LOW = 5'h01;
  localparam logic [4:0] STEP_UNI_HIGH = 5'h0A;
  localparam logic [4:0] STEP_BI_LOW = 5'h02;
  localparam logic [4:0] STEP_BI_HIGH = 5'h14;
  localparam logic [MV_W-1:0] OFS_BI_LOW = 17'h003E8;
  localparam logic [MV_W-1:0] OFS_BI_HIGH = 17'h02710;

  // ************************************************************
  // Channel selector positions.
  // ************************************************************
  localparam logic [1:0] CHAN_LOCAL = 2'h0;
  localparam logic [1:0] CHAN_VOLT = 2'h1;
  localparam logic [1:0] CHAN_CURR = 2'h2;

  // ************************************************************
  // Controller registers on AHB-Lite.
  // ************************************************************
  localparam logic [7:0] REG_SETTING = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam int SET_MAG_LSB = 0;
  localparam int SET_HIGH_BIT = 12;
  localparam int SET_ADDR_LSB = 16;
  localparam logic [31:0] SET_MASK = 32'h001F1FFF;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam logic [2:0] SEQ_LAST = 3'h6;

endpackage : awl_pkg

/* File: verilog/awl_link_if.sv */
/*
 * Byte link between the bus controller and the listener.
 * Assumes the bench joins the two ends through one instance.
 */
interface awl_link_if;
  // Data lines and strobes driven by the talker.
  logic [7:0] dio;
  logic atn;
  logic dav;
  // Handshake lines driven by the listener.
  logic rfd;
  logic dac;

  modport dev (
    input dio,
    input atn,
    input dav,
    output rfd,
    output dac
  );

  modport ctl (
    output dio,
    output atn,
    output dav,
    input rfd,
    input dac
  );
endinterface : awl_link_if

/* File: verilog/awl_sync.sv */
/*
 * Two-flop synchroniser, one stage pair per bit.
 * Assumes the inputs are quasi-static for at least two clocks.
 */
module awl_sync #(
  parameter int W = 1
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_b,
  // Asynchronous inputs and their synchronised copies.
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  // ************************************************************
  // Per-bit double flops.
  // ************************************************************
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic meta_q;
    // The first flop feeds only the second one.
    always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
        meta_q <= 1'b0;
        q[i] <= 1'b0;
      end else begin
        meta_q <= d[i];
        q[i] <= meta_q;
      end
    end
  end

endmodule // awl_sync

/* File: verilog/awl_listener.sv */
/*
 * Listen-only end: takes bytes off the link, tracks its listen address,
 * assembles four-character data words and drives a millivolt setting
 * to the voltage or current channel.
 * Assumes the link and the rear switches are asynchronous pins, and that
 * the controller keeps the byte stable while its valid strobe is high.
 */
module awl_listener (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_b,
  // Link towards the bus controller.
  awl_link_if.dev link,
  // Rear-panel switches.
  input wire logic [4:0] addr_sw,
  input wire logic bipolar_sw,
  input wire logic [1:0] chan_sw,
  // Voltage-limit channel setting.
  output logic signed [awl_pkg::MV_W-1:0] voltage_limit_channel_mv_q,
  output logic voltage_limit_channel_high_q,
  output logic voltage_limit_channel_upd_q,
  // Current-limit channel setting.
  output logic signed [awl_pkg::MV_W-1:0] current_limit_channel_mv_q,
  output logic current_limit_channel_high_q,
  output logic current_limit_channel_upd_q,
  // Status.
  output logic listening_q
);

  // ************************************************************
  // Declarations.
  // ************************************************************
  typedef enum logic {
    AWL_READY = 1'b0,
    AWL_ACCEPT = 1'b1
  } awl_hs_t;

  awl_hs_t hs_q;
  logic [7:0] byte_s;
  logic atn_s;
  logic dav_s;
  logic [4:0] addr_s;
  logic bipolar_s;
  logic [1:0] chan_s;
  logic take;
  logic remote;
  logic accept;
  logic apply;
  logic [1:0] cnt_q;
  logic high_q;
  logic [3:0] hund_q;
  logic [3:0] tens_q;
  logic [10:0] mag;
  logic [4:0] step;
  logic [awl_pkg::MV_W-1:0] ofs;
  logic [15:0] prod;
  logic signed [awl_pkg::MV_W-1:0] mv_d;

  // ************************************************************
  // Input capture.
  // ************************************************************
  // Every link line and switch is a pin, so all pass two flops.
  // The talker puts the byte up a cycle ahead of its strobe, so the
  // equal pipeline delay keeps data valid when the strobe is seen.
  awl_sync #(
    .W(18)
  ) u_sync (
    .mclk(mclk),
    .rst_b(rst_b),
    .d({link.dio, link.atn, link.dav, addr_sw, bipolar_sw, chan_sw}),
    .q({byte_s, atn_s, dav_s, addr_s, bipolar_s, chan_s})
  );

  // ************************************************************
  // Acceptor handshake.
  // ************************************************************
  // Every byte is acknowledged, even ignored ones, so a controller
  // talking to other instruments is never held up by this end.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      hs_q <= AWL_READY;
    end else begin
      case (hs_q)
        AWL_READY: begin
          if (dav_s) begin
            hs_q <= AWL_ACCEPT;
          end
        end
        AWL_ACCEPT: begin
          if (!dav_s) begin
            hs_q <= AWL_READY;
          end
        end
        default: begin
          hs_q <= AWL_READY;
        end
      endcase
    end
  end

  // Only handshake lines leave this end; no data line exists.
  assign link.rfd = (hs_q == AWL_READY);
  assign link.dac = (hs_q == AWL_ACCEPT);
  assign take = (hs_q == AWL_READY) && dav_s;

  // ************************************************************
  // Address tracking.
  // ************************************************************
  // The all-ones switch code equals the unlisten byte, so it can never
  // turn listening on.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      listening_q <= 1'b0;
    end else if (take && atn_s) begin
      if (byte_s == awl_pkg::UNLISTEN) begin
        listening_q <= 1'b0;
      end else if (byte_s == {awl_pkg::LISTEN_GROUP, addr_s} &&
                   addr_s != awl_pkg::ADDR_NONE) begin
        listening_q <= 1'b1;
      end
    end
  end

  // Data counts only while addressed and not in local control.
  assign remote = (chan_s == awl_pkg::CHAN_VOLT) ||
                  (chan_s == awl_pkg::CHAN_CURR);
  assign accept = take && !atn_s && listening_q && remote;
  assign apply = accept && (cnt_q == awl_pkg::DIGIT_LAST);

  // ************************************************************
  // Word assembly.
  // ************************************************************
  // Characters are counted blindly; a stray terminator shifts the word
  // framing, which is the documented behaviour, not a fault.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= awl_pkg::DIGIT_FIRST;
    end else if (accept) begin
      cnt_q <= cnt_q + 2'h1;
    end
  end

  // First character picks the range, next two are held as BCD.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      high_q <= 1'b0;
      hund_q <= 4'h0;
      tens_q <= 4'h0;
    end else if (accept) begin
      case (cnt_q)
        2'h0: high_q <= (byte_s == awl_pkg::CHAR_HIGH);
        2'h1: hund_q <= byte_s[3:0];
        2'h2: tens_q <= byte_s[3:0];
        default: begin
        end
      endcase
    end
  end

  // ************************************************************
  // Scaling.
  // ************************************************************
  // The third magnitude digit comes straight off the link so the new
  // setting is out one cycle after the fourth character.
  assign mag = 11'(hund_q) * 11'h064 + 11'(tens_q) * 11'h00A +
               11'(byte_s[3:0]);

  // Step and offset come from mode and range; 500 lands on 0 in bipolar mode.
  always_comb begin
    if (!bipolar_s) begin
      step = high_q ? awl_pkg::STEP_UNI_HIGH
                    : awl_pkg::STEP_UNI_LOW;
      ofs = '0;
    end else begin
      step = high_q ? awl_pkg::STEP_BI_HIGH
                    : awl_pkg::STEP_BI_LOW;
      ofs = high_q ? awl_pkg::OFS_BI_HIGH
                   : awl_pkg::OFS_BI_LOW;
    end
  end

  assign prod = 16'(mag) * 16'(step);
  assign mv_d = $signed({1'b0, prod} - ofs);

  // ************************************************************
  // Channel outputs.
  // ************************************************************
  // One channel at a time; the other keeps its last setting.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      voltage_limit_channel_mv_q <= '0;
      voltage_limit_channel_high_q <= 1'b0;
      voltage_limit_channel_upd_q <= 1'b0;
    end else begin
      voltage_limit_channel_upd_q <= 1'b0;
      if (apply && chan_s == awl_pkg::CHAN_VOLT) begin
        voltage_limit_channel_mv_q <= mv_d;
        voltage_limit_channel_high_q <= high_q;
        voltage_limit_channel_upd_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      current_limit_channel_mv_q <= '0;
      current_limit_channel_high_q <= 1'b0;
      current_limit_channel_upd_q <= 1'b0;
    end else begin
      current_limit_channel_upd_q <= 1'b0;
      if (apply && chan_s == awl_pkg::CHAN_CURR) begin
        current_limit_channel_mv_q <= mv_d;
        current_limit_channel_high_q <= high_q;
        current_limit_channel_upd_q <= 1'b1;
      end
    end
  end

endmodule // awl_listener

/* File: tb/awl_link_sva.sv */
/*
 * Checker for handshake timing and word framing on the byte link.
 * Assumes it watches the link that joins the two design ends.
 */
module awl_link_sva (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_b,
  // Link signals.
  input wire logic [7:0] dio,
  input wire logic atn,
  input wire logic dav,
  input wire logic rfd,
  input wire logic dac
);
  timeunit 1ns;
  timeprecision 1ns;

  // ************************************************************
  // Framing trackers.
  // ************************************************************
  logic dav_q;
  logic lsn_q;
  logic [1:0] cnt_q;
  logic take;

  // A byte is offered when its strobe rises.
  assign take = dav && !dav_q;

  // Strobe history for edge detection.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) dav_q <= 1'b0;
    else dav_q <= dav;
  end

  // Listen addresses the far end; unlisten drops it.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) lsn_q <= 1'b0;
    else if (take && atn && dio[7:5] == awl_pkg::LISTEN_GROUP)
      lsn_q <= (dio != awl_pkg::UNLISTEN);
  end

  // Data characters counted modulo one word.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) cnt_q <= 2'h0;
    else if (take && !atn) cnt_q <= cnt_q + 2'h1;
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);

  property p_ack_delay; $rose(dav) |-> ##[2:3] dac; endproperty
  a_ack_delay: assert property (p_ack_delay)
    else $error("acknowledge late");
  property p_ack_hold; dac && dav |=> dac; endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("acknowledge dropped early");
  property p_ack_drop; $fell(dav) |-> ##[2:3] (!dac && rfd); endproperty
  a_ack_drop: assert property (p_ack_drop)
    else $error("acknowledge not released");
  property p_excl; !(rfd && dac); endproperty
  a_excl: assert property (p_excl)
    else $error("ready and accepted together");
  property p_ack_cause; $rose(dac) |-> dav; endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("acknowledge without byte");
  property p_addr_first; take && !atn |-> lsn_q; endproperty
  a_addr_first: assert property (p_addr_first)
    else $error("data sent unaddressed");
  property p_range;
    take && !atn && cnt_q == 2'h0 |->
      (dio == awl_pkg::CHAR_LOW || dio == awl_pkg::CHAR_HIGH);
  endproperty
  a_range: assert property (p_range)
    else $error("bad range character");
  property p_digit;
    take && !atn && cnt_q != 2'h0 |->
      dio[7:4] == awl_pkg::DIGIT_ZONE && dio[3:0] <= 4'h9;
  endproperty
  a_digit: assert property (p_digit)
    else $error("bad magnitude digit");
  property p_whole;
    take && atn && dio == awl_pkg::UNLISTEN |-> cnt_q == 2'h0;
  endproperty
  a_whole: assert property (p_whole)
    else $error("word not four characters");
  property p_stable; dav && $past(dav) |-> $stable(dio) && $stable(atn);
  endproperty
  a_stable: assert property (p_stable)
    else $error("byte changed under strobe");
endmodule // awl_link_sva

/* File: tb/ascii_word_dac_listener_tb.sv */
/*
 * Bench for both ends, plus a second listener fed directly.
 * Assumes the design files and checker are compiled first.
 */
module ascii_word_dac_listener_tb;
  timeunit 1ns;
  timeprecision 1ns;

  // ************************************************************
  // Signals and instances.
  // ************************************************************
  logic mclk, rst_b, hsel, hwrite, hready, hreadyout, hresp, bipolar_sw;
  logic [7:0] haddr;
  logic [1:0] htrans, chan_sw;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata;
  logic [4:0] addr_sw, sw2;
  logic signed [16:0] v_mv, c_mv, l2_mv;
  logic v_hi, c_hi, v_upd, c_upd, lsn, l2_upd, l2_lsn;
  int error_cnt, checks_done, v_cnt, c_cnt, l2_cnt, seed, n0;
  awl_link_if link ();
  awl_link_if link2 ();
  assign hready = hreadyout;

  awl_talker awl_talker_inst (.mclk(mclk), .rst_b(rst_b), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .link(link));
  awl_listener awl_listener_inst (.mclk(mclk), .rst_b(rst_b), .link(link),
    .addr_sw(addr_sw), .bipolar_sw(bipolar_sw), .chan_sw(chan_sw),
    .voltage_limit_channel_mv_q(v_mv), .voltage_limit_channel_high_q(v_hi),
    .voltage_limit_channel_upd_q(v_upd), .current_limit_channel_mv_q(c_mv),
    .current_limit_channel_high_q(c_hi), .current_limit_channel_upd_q(c_upd),
    .listening_q(lsn));
  // Second listener: unipolar voltage use, fed by the bench.
  awl_listener awl_listener_inst2 (.mclk(mclk), .rst_b(rst_b),
    .link(link2), .addr_sw(sw2), .bipolar_sw(1'b0), .chan_sw(2'h1),
    .voltage_limit_channel_mv_q(l2_mv), .voltage_limit_channel_high_q(),
    .voltage_limit_channel_upd_q(l2_upd), .current_limit_channel_mv_q(),
    .current_limit_channel_high_q(), .current_limit_channel_upd_q(),
    .listening_q(l2_lsn));
  awl_link_sva awl_link_sva_inst (.mclk(mclk), .rst_b(rst_b),
    .dio(link.dio), .atn(link.atn), .dav(link.dav), .rfd(link.rfd),
    .dac(link.dac));

  // Free-running 50 MHz clock.
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // Pulses are counted so routing shows when a value repeats.
  always @(posedge mclk) begin
    if (v_upd === 1'b1) v_cnt++;
    if (c_upd === 1'b1) c_cnt++;
    if (l2_upd === 1'b1) l2_cnt++;
  end

  // ************************************************************
  // Helpers.
  // ************************************************************
  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Millivolts from the scaling rules.
  function automatic logic signed [16:0] exp_mv(input int m, input logic hi,
                                                input logic bip);
    int st;
    st = bip ? (hi ? 20 : 2) : (hi ? 10 : 1);
    return 17'(m * st - (bip ? (hi ? 10000 : 1000) : 0));
  endfunction

  function automatic logic [11:0] bcd(input int m);
    return {4'(m / 100), 4'(m / 10 % 10), 4'(m % 10)};
  endfunction

  // One single-word transfer; entered just after a rising edge.
  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    int n;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    hsize <= 3'h2;
    n = 0;
    do begin @(posedge mclk); n++; end while (hready !== 1'b1 && n < 50);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do begin @(posedge mclk); n++; end while (hready !== 1'b1 && n < 100);
    rd = hrdata;
    if (n >= 100) begin error_cnt++; final_report(); end
  endtask

  // Sends one setting and checks where it landed.
  task automatic word(input int m, input logic hi, input logic [4:0] adr,
                      input logic [4:0] sw, input logic [1:0] ch,
                      input logic bip);
    logic [31:0] wd, rd;
    logic signed [16:0] pv, pc;
    int n, v0, c0;
    logic go;
    go = sw == adr && sw != 5'h1F && (ch == 2'h1 || ch == 2'h2);
    pv = (go && ch == 2'h1) ? exp_mv(m, hi, bip) : v_mv;
    pc = (go && ch == 2'h2) ? exp_mv(m, hi, bip) : c_mv;
    v0 = v_cnt;
    c0 = c_cnt;
    addr_sw <= sw;
    bipolar_sw <= bip;
    chan_sw <= ch;
    wd = ($random(seed) & ~awl_pkg::SET_MASK) | {11'h000, adr, 3'h0, hi,
      bcd(m)};
    repeat (3) @(posedge mclk);
    ahb(1'b1, awl_pkg::REG_SETTING, wd, rd);
    ahb(1'b0, awl_pkg::REG_SETTING, 32'h0, rd);
    chk("setting", rd, wd & awl_pkg::SET_MASK);
    n = 0;
    do begin
      ahb(1'b0, awl_pkg::REG_STATUS, 32'h0, rd);
      n++;
    end while (rd[1] !== 1'b1 && n < 300);
    if (n >= 300) begin error_cnt++; final_report(); end
    ahb(1'b1, awl_pkg::REG_STATUS, 32'h2, rd);
    chk("listen", lsn, 1'b0);
    chk("volt count", v_cnt - v0, go && ch == 2'h1);
    chk("curr count", c_cnt - c0, go && ch == 2'h2);
    chk("volt mv", v_mv, pv);
    chk("curr mv", c_mv, pc);
    if (go) chk("range", ch == 2'h1 ? v_hi : c_hi, hi);
  endtask

  // Byte on the second link; it shows the inverse once freed.
  task automatic send2(input logic a, input logic [7:0] b);
    int n;
    link2.dio <= b;
    link2.atn <= a;
    @(posedge mclk);
    link2.dav <= 1'b1;
    n = 0;
    do begin @(posedge mclk); n++; end while (link2.dac !== 1'b1 && n < 20);
    link2.dav <= 1'b0;
    do begin @(posedge mclk); n++; end while (link2.dac !== 1'b0 && n < 40);
    link2.dio <= ~b;
    @(posedge mclk);
    if (n >= 40) begin error_cnt++; final_report(); end
  endtask

  task automatic str2(input string s);
    for (int i = 0; i < s.len(); i++) send2(1'b0, s[i]);
  endtask

  task automatic do_reset();
    rst_b <= 1'b0;
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
  endtask

  // ************************************************************
  // Main sequence.
  // ************************************************************
  initial begin
    int mags[3];
    logic [31:0] rd;
    mags = '{0, 500, 999};
    seed = 32'h40573333;
    {hsel, hwrite, htrans, haddr, hsize, hwdata} = '0;
    {addr_sw, bipolar_sw, chan_sw} = '0;
    sw2 = 5'h06;
    {link2.dio, link2.atn, link2.dav} = '0;
    do_reset();
    ahb(1'b0, 8'h08, 32'h0, rd);
    chk("unmapped", rd, 32'h0);
    // Every mode, range and end or mid code.
    for (int i = 0; i < 12; i++)
      word(mags[i % 3], 1'((i / 3) % 2), 5'h06, 5'h06, 2'(1 + i % 2),
        1'(i / 6));
    word(250, 1'b0, 5'h03, 5'h04, 2'h1, 1'b0);
    word(250, 1'b0, 5'h03, 5'h03, 2'h3, 1'b0);
    // Random settings, switches and address mismatches.
    for (int i = 0; i < 16; i++) begin
      int m;
      logic [4:0] a;
      m = $unsigned($random(seed)) % 1000;
      a = 5'($unsigned($random(seed)) % 31);
      word(m, 1'($random(seed)), a,
        ($random(seed) % 5 == 0) ? a ^ 5'h01 : a, 2'($random(seed)),
        1'($random(seed)));
    end
    // Second listener: stray characters and reset.
    send2(1'b1, 8'h55);
    send2(1'b1, 8'h26);
    n0 = l2_cnt;
    str2("1250\015\012");
    chk("l2 count", l2_cnt - n0, 32'h1);
    chk("l2 mv", l2_mv, 32'hFA);
    str2("12");
    chk("l2 stray", l2_cnt - n0, 32'h2);
    str2("5");
    do_reset();
    send2(1'b1, 8'h55);
    send2(1'b1, 8'h26);
    n0 = l2_cnt;
    str2("1250");
    chk("l2 reset", l2_cnt - n0, 32'h1);
    chk("l2 mv2", l2_mv, 32'hFA);
    send2(1'b1, 8'h3F);
    str2("1999");
    chk("l2 unaddr", l2_cnt - n0, 32'h1);
    sw2 <= 5'h1F;
    repeat (3) @(posedge mclk);
    send2(1'b1, 8'h3F);
    str2("1999");
    chk("l2 ones", l2_lsn, 32'h0);
    chk("l2 ones mv", l2_mv, 32'hFA);
    final_report();
  end
endmodule // ascii_word_dac_listener_tb
